// File: common/spl_pkg.sv
`default_nettype none
package spl_pkg;

    localparam int NLANE = 40;
    localparam int NGRP  = 10;
    localparam int NPORT = 16;
    localparam int NCNT  = 5;
    localparam int MEM_AW = 6;

    // Register map
    localparam logic [23:0] PCW_BASE   = 24'h00015c;
    localparam int          PCW_SHIFT  = 5;
    localparam logic [23:0] LGC_BASE   = 24'hff0000;
    localparam int          LGC_SHIFT  = 12;
    localparam logic [23:0] SGC_ADDR   = 24'hf2000c;
    localparam logic [23:0] CNT_BASE   = 24'hf40000;
    localparam int          CNT_SHIFT  = 5;

    // Reset values and counter saturation value
    localparam logic [31:0] PCW_RST = 32'h0000_0000;
    localparam logic [31:0] LGC_RST = 32'h0000_0000;
    localparam logic [31:0] SGC_RST = 32'h0000_0000;
    localparam logic [31:0] CNT_MAX = 32'hffff_ffff;

    // Port control word fields
    localparam int PCW_FORCE_NARROW = 24;
    // Lane group config fields (A = lanes 0-1, B = lanes 2-3 of split groups; other groups use A for all lanes)
    localparam int LGC_SPLIT    = 0;
    localparam int LGC_RATE_A   = 1;
    localparam int LGC_RATE_B   = 3;
    localparam int LGC_EMPH_A   = 5;
    localparam int LGC_EMPH_B   = 7;
    localparam int LGC_DRIVE_A  = 9;
    localparam int LGC_DRIVE_B  = 11;
    localparam int LGC_RESET_A  = 13;
    localparam int LGC_RESET_B  = 14;
    localparam int LGC_REINIT_A = 15;
    localparam int LGC_REINIT_B = 16;
    // Switch global control fields
    localparam int SGC_EARLY    = 0;

    // Split-capable groups and their first single-lane ports
    localparam int SPLIT_GRP_A  = 4;
    localparam int SPLIT_GRP_B  = 9;
    localparam int SPLIT_BASE_A = 4;
    localparam int SPLIT_BASE_B = 12;
    localparam int HIGH_GRP_OFS = 3;

    // Counter indices
    localparam int CNT_ACCEPT = 0;
    localparam int CNT_REFUSE = 1;
    localparam int CNT_SENT   = 2;
    localparam int CNT_TRACE  = 3;
    localparam int CNT_FILTER = 4;

    typedef enum logic [1:0] {
        SPL_K_DATA,
        SPL_K_STOMP,
        SPL_K_IDLE
    } spl_kind_t;

    typedef struct packed {
        logic [31:0] data;
        logic        sop;
        logic        eop;
        logic [3:0]  dest;
    } spl_word_t;

    typedef struct packed {
        spl_kind_t kind;
        spl_word_t w;
    } spl_sym_t;

    typedef struct packed {
        logic       active;
        logic [3:0] port;
        logic [1:0] rate;
        logic [1:0] emph;
        logic [1:0] drive;
        logic       rst;
        logic       reinit;
    } spl_lane_t;

endpackage : spl_pkg
`default_nettype wire

// File: hdl/spl_port_layer.sv
`timescale 1ns/1ps
`default_nettype none
module spl_port_layer
    import spl_pkg::*;
(
    // Clock and reset
    input  wire logic                    i_clk,
    input  wire logic                    i_reset,
    input  wire logic                    i_ce,
    // Register port
    input  wire logic                    i_reg_wr,
    input  wire logic                    i_reg_rd,
    input  wire logic [23:0]             i_reg_addr,
    input  wire logic [31:0]             i_reg_wdata,
    output logic      [31:0]             o_reg_rdata,
    output logic                         o_reg_ack,
    // Ingress stream
    input  wire logic                    i_in_valid,
    input  wire spl_word_t               i_in,
    input  wire logic                    i_in_bad,
    output logic                         o_in_ready,
    // Egress stream
    output logic                         o_out_valid,
    output spl_sym_t                     o_out,
    input  wire logic                    i_out_ready,
    // Counter events, one bit per port
    input  wire logic [NPORT-1:0]        i_ev_accept,
    input  wire logic [NPORT-1:0]        i_ev_refuse,
    input  wire logic [NPORT-1:0]        i_ev_trace,
    input  wire logic [NPORT-1:0]        i_ev_filter,
    // Lane setup
    output spl_lane_t [NLANE-1:0]        o_lane
);

    ////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic [4:0] dec_idx(input logic [23:0] a,
                                           input logic [23:0] base,
                                           input int          sh,
                                           input int          n);
        logic [23:0] off;
        logic [23:0] idx;
        off = a - base;
        idx = off >> sh;
        dec_idx = 5'h00;
        if (a >= base && idx < 24'(n) && off[1:0] == 2'b00 &&
            (off & ((24'h000001 << sh) - 24'h000001)) == 24'h000000)
            dec_idx = {1'b1, idx[3:0]};
    endfunction : dec_idx

    function automatic spl_lane_t lane_map(input int          l,
                                           input logic [31:0] g,
                                           input logic [31:0] p);
        int   grp;
        int   k;
        int   base;
        logic split;
        logic hb;
        grp   = l / 4;
        k     = l % 4;
        split = (grp == SPLIT_GRP_A) || (grp == SPLIT_GRP_B);
        base  = (grp == SPLIT_GRP_A) ? SPLIT_BASE_A : SPLIT_BASE_B;
        hb    = split && (k >= 2);
        lane_map = '0;
        if (split && g[LGC_SPLIT]) begin
            lane_map.active = 1'b1;
            lane_map.port   = 4'(base + k);
        end else if (p[PCW_FORCE_NARROW]) begin
            lane_map.active = (k == 0);
            if (split)
                lane_map.port = 4'(base);
            else if (grp < SPLIT_GRP_A)
                lane_map.port = 4'(grp);
            else
                lane_map.port = 4'(grp + HIGH_GRP_OFS);
        end else begin
            lane_map.active = 1'b1;
            lane_map.port   = 4'(grp);
        end
        lane_map.rate   = hb ? g[LGC_RATE_B +: 2]  : g[LGC_RATE_A +: 2];
        lane_map.emph   = hb ? g[LGC_EMPH_B +: 2]  : g[LGC_EMPH_A +: 2];
        lane_map.drive  = hb ? g[LGC_DRIVE_B +: 2] : g[LGC_DRIVE_A +: 2];
        lane_map.rst    = hb ? g[LGC_RESET_B]  : g[LGC_RESET_A];
        lane_map.reinit = hb ? g[LGC_REINIT_B] : g[LGC_REINIT_A];
    endfunction : lane_map

    ////////////////////////////////////////////////////////////////////////
    // Register decode

    logic [31:0]              pcw_q [NPORT];
    logic [31:0]              lgc_q [NGRP];
    logic [31:0]              sgc_q;
    logic [31:0]              cnt_q [NPORT][NCNT];
    logic [4:0]               pcw_hit;
    logic [4:0]               lgc_hit;
    logic [4:0]               cnt_hit;
    logic [23:0]              cnt_off;
    logic [2:0]               cnt_sel;
    logic                     cnt_ok;
    logic                     early;

    assign pcw_hit = dec_idx(i_reg_addr, PCW_BASE, PCW_SHIFT, NPORT);
    assign lgc_hit = dec_idx(i_reg_addr, LGC_BASE, LGC_SHIFT, NGRP);
    assign cnt_hit = dec_idx(i_reg_addr & ~24'h00001f, CNT_BASE,
                             CNT_SHIFT, NPORT);
    assign cnt_off = i_reg_addr - CNT_BASE;
    assign cnt_sel = cnt_off[4:2];
    assign cnt_ok  = cnt_hit[4] && cnt_off[1:0] == 2'b00 &&
                     cnt_sel < 3'(NCNT);
    assign early   = sgc_q[SGC_EARLY];

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            for (int i = 0; i < NPORT; i++)
                pcw_q[i] <= PCW_RST;
            sgc_q <= SGC_RST;
        end else if (i_ce && i_reg_wr) begin
            if (pcw_hit[4])
                pcw_q[pcw_hit[3:0]] <= i_reg_wdata;
            if (i_reg_addr == SGC_ADDR)
                sgc_q <= i_reg_wdata;
        end
    end

    // Reset and reinit request bits clear themselves after one cycle
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            for (int i = 0; i < NGRP; i++)
                lgc_q[i] <= LGC_RST;
        end else if (i_ce) begin
            for (int i = 0; i < NGRP; i++) begin
                if (i_reg_wr && lgc_hit[4] && lgc_hit[3:0] == 4'(i))
                    lgc_q[i] <= i_reg_wdata;
                else begin
                    lgc_q[i][LGC_RESET_A]  <= 1'b0;
                    lgc_q[i][LGC_RESET_B]  <= 1'b0;
                    lgc_q[i][LGC_REINIT_A] <= 1'b0;
                    lgc_q[i][LGC_REINIT_B] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_reg_ack   <= 1'b0;
            o_reg_rdata <= 32'h0000_0000;
        end else if (i_ce) begin
            o_reg_ack   <= i_reg_wr || i_reg_rd;
            o_reg_rdata <= 32'h0000_0000;
            if (i_reg_rd) begin
                if (pcw_hit[4])
                    o_reg_rdata <= pcw_q[pcw_hit[3:0]];
                else if (lgc_hit[4])
                    o_reg_rdata <= lgc_q[lgc_hit[3:0]];
                else if (i_reg_addr == SGC_ADDR)
                    o_reg_rdata <= sgc_q;
                else if (cnt_ok)
                    o_reg_rdata <= cnt_q[cnt_hit[3:0]][cnt_sel];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lane map

    for (genvar l = 0; l < NLANE; l++) begin : g_lane
        always_ff @(posedge i_clk or posedge i_reset) begin
            if (i_reset)
                o_lane[l] <= '0;
            else if (i_ce)
                o_lane[l] <= lane_map(l, lgc_q[l / 4], pcw_q[l / 4]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Packet store

    spl_word_t                mem [2**MEM_AW];
    logic [MEM_AW:0]          wptr_q;
    logic [MEM_AW:0]          wptr_d;
    logic [MEM_AW:0]          start_q;
    logic [MEM_AW:0]          commit_q;
    logic [MEM_AW:0]          rptr_q;
    logic [MEM_AW:0]          rptr_d;
    logic [MEM_AW:0]          pstart_q;
    logic [MEM_AW:0]          limit;
    logic [MEM_AW:0]          used_d;
    logic                     in_take;
    logic                     in_bad_eop;
    logic                     rd_inpkt_q;
    logic                     rd_inpkt_d;
    logic                     stomp_q;
    logic                     cur_started;
    logic                     push;
    spl_sym_t                 push_sym;
    spl_word_t                rd_word;
    logic [1:0]               f_cnt_q;
    logic                     pop;

    assign in_take     = i_in_valid && o_in_ready;
    assign in_bad_eop  = in_take && i_in.eop && i_in_bad;
    // Early mode reads up to the write pointer, else up to the last good eop
    assign limit       = early ? wptr_q : commit_q;
    assign rd_word     = mem[rptr_q[MEM_AW-1:0]];
    assign cur_started = rd_inpkt_q && pstart_q == start_q;
    assign pop         = o_out_valid && i_out_ready;

    // Reader: stomp first, then data, then idle fill inside a packet
    always_comb begin
        push       = 1'b0;
        push_sym   = '0;
        rptr_d     = rptr_q;
        rd_inpkt_d = rd_inpkt_q;
        if (f_cnt_q < 2'd2 || pop) begin
            if (stomp_q) begin
                push          = 1'b1;
                push_sym.kind = SPL_K_STOMP;
                rd_inpkt_d    = 1'b0;
            end else if (rptr_q != limit) begin
                push          = 1'b1;
                push_sym.kind = SPL_K_DATA;
                push_sym.w    = rd_word;
                rptr_d        = rptr_q + 1'b1;
                rd_inpkt_d    = !rd_word.eop;
            end else if (rd_inpkt_q) begin
                push          = 1'b1;
                push_sym.kind = SPL_K_IDLE;
            end
        end
    end

    always_comb begin
        wptr_d = wptr_q;
        if (in_bad_eop)
            wptr_d = cur_started ? rptr_d : start_q;
        else if (in_take)
            wptr_d = wptr_q + 1'b1;
        used_d = wptr_d - rptr_d;
    end

    always_ff @(posedge i_clk) begin
        if (i_ce && in_take && !in_bad_eop)
            mem[wptr_q[MEM_AW-1:0]] <= i_in;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            wptr_q     <= '0;
            start_q    <= '0;
            commit_q   <= '0;
            o_in_ready <= 1'b0;
        end else if (i_ce) begin
            wptr_q     <= wptr_d;
            o_in_ready <= used_d < (MEM_AW + 1)'(2**MEM_AW - 1);
            if (in_take && i_in.sop)
                start_q <= wptr_q;
            if (in_take && i_in.eop && !i_in_bad)
                commit_q <= wptr_q + 1'b1;
            else if (in_bad_eop && cur_started)
                commit_q <= rptr_d;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rptr_q     <= '0;
            rd_inpkt_q <= 1'b0;
            pstart_q   <= '0;
            stomp_q    <= 1'b0;
        end else if (i_ce) begin
            rptr_q     <= rptr_d;
            rd_inpkt_q <= rd_inpkt_d;
            if (push && push_sym.kind == SPL_K_DATA && rd_word.sop)
                pstart_q <= rptr_q;
            if (in_bad_eop && cur_started)
                stomp_q <= 1'b1;
            else if (push && push_sym.kind == SPL_K_STOMP)
                stomp_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-entry output buffer

    spl_sym_t                 f_q [2];

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            f_cnt_q     <= 2'd0;
            o_out_valid <= 1'b0;
            f_q[0]      <= '0;
            f_q[1]      <= '0;
        end else if (i_ce) begin
            if (pop) begin
                f_q[0] <= f_q[1];
                if (push)
                    f_q[f_cnt_q == 2'd2 ? 1 : 0] <= push_sym;
            end else if (push) begin
                f_q[f_cnt_q[0]] <= push_sym;
            end
            f_cnt_q     <= f_cnt_q + 2'(push) - 2'(pop);
            o_out_valid <= (f_cnt_q + 2'(push) - 2'(pop)) != 2'd0;
        end
    end

    assign o_out = f_q[0];

    ////////////////////////////////////////////////////////////////////////
    // Statistics counters

    logic [NPORT-1:0]         ev_sent;
    logic [NPORT-1:0]         ev [NCNT];

    // Only a data eop counts as sent; a stomped packet never has one
    always_comb begin
        ev_sent = '0;
        if (pop && o_out.kind == SPL_K_DATA && o_out.w.eop)
            ev_sent[o_out.w.dest] = 1'b1;
    end

    assign ev[CNT_ACCEPT] = i_ev_accept;
    assign ev[CNT_REFUSE] = i_ev_refuse;
    assign ev[CNT_SENT]   = ev_sent;
    assign ev[CNT_TRACE]  = i_ev_trace;
    assign ev[CNT_FILTER] = i_ev_filter;

    for (genvar p = 0; p < NPORT; p++) begin : g_port
        for (genvar c = 0; c < NCNT; c++) begin : g_cnt
            logic rd_hit;
            assign rd_hit = i_reg_rd && cnt_ok &&
                            cnt_hit[3:0] == 4'(p) && cnt_sel == 3'(c);
            // An event in the read cycle is kept as a count of one
            always_ff @(posedge i_clk or posedge i_reset) begin
                if (i_reset)
                    cnt_q[p][c] <= 32'h0000_0000;
                else if (i_ce) begin
                    if (rd_hit)
                        cnt_q[p][c] <= 32'(ev[c][p]);
                    else if (ev[c][p] && cnt_q[p][c] != CNT_MAX)
                        cnt_q[p][c] <= cnt_q[p][c] + 32'h0000_0001;
                end
            end
        end
    end

endmodule : spl_port_layer
`default_nettype wire

// File: test/spl_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module spl_far_end
    import spl_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    // Pace: 0 prompt, 1 random stalls, 2 hold off
    input  wire logic [1:0] i_mode,
    // Symbols from the switch
    input  wire logic       i_valid,
    input  wire spl_sym_t   i_sym,
    output logic            o_ready,
    // Whole packets accepted
    output logic [15:0]     o_pkts
);
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset)
            o_ready <= 1'b0;
        else
            o_ready <= (i_mode == 2'd0) || (i_mode == 2'd1 && $urandom % 2);
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset)
            o_pkts <= 16'h0;
        else if (i_valid && o_ready && i_sym.kind == SPL_K_DATA
                 && i_sym.w.eop)
            o_pkts <= o_pkts + 16'h1;
    end
endmodule : spl_far_end
`default_nettype wire

// File: test/spl_port_layer_sva.sv
`timescale 1ns/1ps
`default_nettype none
module spl_port_layer_sva
    import spl_pkg::*;
(
    // Clock and reset
    input wire logic                  i_clk,
    input wire logic                  i_reset,
    input wire logic                  i_ce,
    // Register port
    input wire logic                  i_reg_wr,
    input wire logic                  i_reg_rd,
    input wire logic [31:0]           o_reg_rdata,
    input wire logic                  o_reg_ack,
    // Egress and lanes
    input wire logic                  o_out_valid,
    input wire spl_sym_t              o_out,
    input wire logic                  i_out_ready,
    input wire spl_lane_t [NLANE-1:0] o_lane
);
    logic req;
    logic in_pkt_q;

    assign req = i_ce && (i_reg_wr || i_reg_rd);

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset)
            in_pkt_q <= 1'b0;
        else if (i_ce && o_out_valid && i_out_ready &&
                 o_out.kind != SPL_K_IDLE)
            in_pkt_q <= (o_out.kind == SPL_K_DATA) && !o_out.w.eop;
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    ////////////////////////////////////////////////////////////////////////
    chk_reg_ack: assert property (req |=> o_reg_ack)
        else $error("register access not acknowledged");
    chk_ack_cause: assert property (o_reg_ack && $past(i_ce) |-> $past(req))
        else $error("acknowledge without access");
    chk_rdata_idle: assert property (!o_reg_ack |-> o_reg_rdata == 32'h0)
        else $error("read data outside acknowledge");
    chk_out_hold: assert property (o_out_valid && !i_out_ready && i_ce
        |=> o_out_valid && $stable(o_out))
        else $error("egress symbol changed while stalled");
    chk_idle_inside: assert property (o_out_valid
        && o_out.kind == SPL_K_IDLE |-> in_pkt_q)
        else $error("idle fill outside a packet");
    chk_stomp_inside: assert property (o_out_valid
        && o_out.kind == SPL_K_STOMP |-> in_pkt_q)
        else $error("stomp outside a packet");
    chk_sop_first: assert property (o_out_valid && o_out.kind == SPL_K_DATA
        && !in_pkt_q |-> o_out.w.sop)
        else $error("packet data without start");
    chk_split_a_map: assert property (o_lane[17].active
        |-> o_lane[17].port inside {4'h4, 4'h5})
        else $error("lane 17 on wrong port");
    chk_split_b_map: assert property (o_lane[39].active
        |-> o_lane[39].port inside {4'h9, 4'hf})
        else $error("lane 39 on wrong port");
    chk_wide_map: assert property (o_lane[22].active
        |-> o_lane[22].port == 4'h5)
        else $error("lane 22 on wrong port");
    chk_rst_pulse: assert property (o_lane[36].rst |=> !o_lane[36].rst)
        else $error("lane reset not a single pulse");

    cover property (o_out_valid && o_out.kind == SPL_K_STOMP);
    cover property (o_out_valid && o_out.kind == SPL_K_IDLE);
    cover property (o_lane[17].active && o_lane[17].port == 4'h5);
    cover property (o_out_valid && !i_out_ready);
endmodule : spl_port_layer_sva

bind spl_port_layer spl_port_layer_sva spl_port_layer_sva_i (
    .i_clk, .i_reset, .i_ce, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
    .o_reg_ack, .o_out_valid, .o_out, .i_out_ready, .o_lane
);
`default_nettype wire

// File: test/spl_port_layer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spl_port_layer_tb import spl_pkg::*;;
    logic                  clk, rst, wr, rd, iv, bad, ack, irdy;
    logic                  ov, ordy, early;
    logic [23:0]           addr;
    logic [31:0]           wd, rdat;
    logic [1:0]            mode;
    logic [15:0]           pkts;
    logic [NPORT-1:0]      eva, evr, evt, evf;
    spl_word_t             iw;
    spl_sym_t              osym, e_sym;
    spl_lane_t [NLANE-1:0] lane;
    spl_sym_t              exp_q[$];
    int                    error_cnt, checks_done, idles;
    time                   t_in, t_out;

    spl_port_layer spl_port_layer_i (
        .i_clk(clk), .i_reset(rst), .i_ce(1'b1),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
        .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_reg_ack(ack),
        .i_in_valid(iv), .i_in(iw), .i_in_bad(bad), .o_in_ready(irdy),
        .o_out_valid(ov), .o_out(osym), .i_out_ready(ordy),
        .i_ev_accept(eva), .i_ev_refuse(evr), .i_ev_trace(evt),
        .i_ev_filter(evf), .o_lane(lane)
    );

    spl_far_end spl_far_end_i (
        .i_clk(clk), .i_reset(rst), .i_mode(mode), .i_valid(ov),
        .i_sym(osym), .o_ready(ordy), .o_pkts(pkts)
    );

    always #10 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    task automatic wr_reg(input logic [23:0] a, input logic [31:0] d);
        @(negedge clk);
        wr   = 1'b1;
        addr = a;
        wd   = d;
        @(negedge clk);
        wr = 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [23:0] a, output logic [31:0] d);
        @(negedge clk);
        rd   = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        d  = rdat;
    endtask : rd_reg

    function automatic logic [23:0] cnt_a(int p, int k);
        return CNT_BASE + 24'(p << CNT_SHIFT) + 24'(k * 4);
    endfunction : cnt_a

    function automatic logic [4:0] exp_lane(int l, logic [9:0] nar,
                                            logic [9:0] spl);
        int g = l / 4;
        int k = l % 4;
        int b = (g == SPLIT_GRP_A) ? SPLIT_BASE_A : SPLIT_BASE_B;
        if ((g == SPLIT_GRP_A || g == SPLIT_GRP_B) && spl[g])
            return {1'b1, 4'(b + k)};
        if (!nar[g])
            return {1'b1, 4'(g)};
        if (k != 0)
            return 5'h0;
        if (g == SPLIT_GRP_A || g == SPLIT_GRP_B)
            return {1'b1, 4'(b)};
        return {1'b1, 4'(g < SPLIT_GRP_A ? g : g + HIGH_GRP_OFS)};
    endfunction : exp_lane

    task automatic send(input logic [3:0] d, input int n, input logic b,
                        input int gap);
        spl_sym_t s;
        int       w;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            if (gap > 0 && i == n / 2) begin
                iv = 1'b0;
                repeat (gap) @(negedge clk);
            end
            iv      = 1'b1;
            iw.data = $urandom;
            iw.sop  = (i == 0);
            iw.eop  = (i == n - 1);
            iw.dest = d;
            bad     = b && (i == n - 1);
            w = 0;
            while (!irdy && w < 500) begin
                @(negedge clk);
                w++;
            end
            chk(w < 500, 1);
            if (i == 0)
                t_in = $time;
            s.kind = (b && i == n - 1) ? SPL_K_STOMP : SPL_K_DATA;
            s.w    = iw;
            if (!b || early)
                exp_q.push_back(s);
        end
        @(negedge clk);
        iv  = 1'b0;
        bad = 1'b0;
    endtask : send

    task automatic drain;
        int w = 0;
        while (exp_q.size() > 0 && w < 3000) begin
            @(negedge clk);
            w++;
        end
        chk(exp_q.size(), 0);
    endtask : drain

    always @(posedge clk) begin
        if (!rst && ov && ordy && osym.kind == SPL_K_IDLE)
            idles++;
        else if (!rst && ov && ordy) begin
            e_sym = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
            if (osym.kind == SPL_K_DATA && osym.w.sop)
                t_out = $time;
            if (e_sym.kind == SPL_K_STOMP) begin
                chk(osym.kind, e_sym.kind);
            end else begin
                chk(64'(osym), 64'(e_sym));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] v;
        logic [9:0]  nar, spl;
        logic [5:0]  xa, xb;
        logic [3:0]  acc, d;
        time         lat, lat_s;
        int          n, p;
        {clk, wr, rd, iv, bad, early, addr, wd, iw, mode} = '0;
        {eva, evr, evt, evf} = '0;
        {error_cnt, checks_done, idles} = '0;
        rst = 1'b1;
        v = $urandom(32'hdd39);
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        rd_reg(SGC_ADDR, v);
        chk(v, SGC_RST);
        rd_reg(PCW_BASE, v);
        chk(v, PCW_RST);
        rd_reg(LGC_BASE, v);
        chk(v, LGC_RST);
        rd_reg(24'h000100, v);
        chk(v, 32'h0);
        $display("reset values done");
        for (int r = 0; r < 3; r++) begin
            v  = $urandom & 32'h1fe0;
            xa = {2'(r), v[6:5], v[10:9]};
            xb = {2'((r + 1) % 3), v[8:7], v[12:11]};
            wr_reg(LGC_BASE + 24'(SPLIT_GRP_A << LGC_SHIFT),
                   v | 32'(r << LGC_RATE_A) | 32'(xb[5:4] << LGC_RATE_B));
            wr_reg(LGC_BASE, v | 32'(r << LGC_RATE_A));
            repeat (3) @(negedge clk);
            for (int l = 0; l < 4; l++) begin
                chk(lane[l][7:2], xa);
                chk(lane[16 + l][7:2], l < 2 ? xa : xb);
            end
        end
        wr_reg(LGC_BASE + 24'(SPLIT_GRP_B << LGC_SHIFT), 32'h0001_2001);
        acc = 4'h0;
        repeat (4) begin
            acc |= {lane[36].rst, lane[38].rst, lane[36].reinit,
                    lane[38].reinit};
            @(negedge clk);
        end
        chk(acc, 4'b1001);
        $display("lane setup done");
        for (int c = 0; c < 4; c++) begin
            nar = (c == 0) ? 10'h0 : (c == 1) ? 10'h3ff : 10'($urandom);
            spl = (c == 2) ? 10'h3ff : (c == 3) ? 10'($urandom) : 10'h0;
            for (int g = 0; g < NGRP; g++) begin
                wr_reg(PCW_BASE + 24'(g << PCW_SHIFT),
                       32'(nar[g]) << PCW_FORCE_NARROW);
                wr_reg(LGC_BASE + 24'(g << LGC_SHIFT), 32'(spl[g]));
            end
            repeat (3) @(negedge clk);
            for (int l = 0; l < NLANE; l++) begin
                v = {lane[l].active, lane[l].active ? lane[l].port : 4'h0};
                chk(v, exp_lane(l, nar, spl));
            end
        end
        $display("lane map done");
        d = 4'($urandom);
        rd_reg(cnt_a(d, CNT_SENT), v);
        send(d, 12, 1'b0, 0);
        drain;
        lat_s = t_out - t_in;
        send(d, 4, 1'b1, 0);
        wr_reg(SGC_ADDR, 32'h1 << SGC_EARLY);
        early = 1'b1;
        rd_reg(SGC_ADDR, v);
        chk(v, 32'h1);
        send(d, 8, 1'b0, 6);
        send(d, 6, 1'b1, 0);
        drain;
        chk(idles > 0, 1);
        send(d, 2, 1'b0, 0);
        drain;
        lat = t_out - t_in;
        send(d, 12, 1'b0, 0);
        drain;
        chk(t_out - t_in, lat);
        chk(lat < lat_s, 1);
        rd_reg(cnt_a(d, CNT_SENT), v);
        chk(v, 32'h4);
        rd_reg(cnt_a(d, CNT_SENT), v);
        chk(v, 32'h0);
        chk(pkts, 16'h4);
        $display("forwarding done");
        mode = 2'd2;
        fork
            send(d, 70, 1'b0, 0);
            begin
                repeat (120) @(negedge clk);
                chk(irdy, 1'b0);
                mode = 2'd1;
            end
        join
        drain;
        chk(pkts, 16'h5);
        $display("buffer stall done");
        p = $urandom_range(15, 0);
        n = $urandom_range(6, 1);
        for (int k = 0; k < NCNT; k++)
            rd_reg(cnt_a(p, k), v);
        repeat (n) begin
            @(negedge clk);
            {eva[p], evr[p], evt[p], evf[p]} = 4'hf;
            @(negedge clk);
            {eva, evr, evt, evf} = '0;
        end
        for (int k = 0; k < NCNT; k++) begin
            rd_reg(cnt_a(p, k), v);
            chk(v, k == CNT_SENT ? 32'h0 : 32'(n));
        end
        rd_reg(cnt_a(p, CNT_REFUSE), v);
        chk(v, 32'h0);
        $display("counters done");
        close_out;
    end

    initial begin
        #1_000_000;
        error_cnt++;
        close_out;
    end
endmodule : spl_port_layer_tb
`default_nettype wire
